//--- rtl/acc_ctrl.sv
/*
  acc_ctrl: analog comparator control and status register with event
  detection, interrupt flag, and routing to timer input capture.
  assumes: cpu strobes are one-cycle pulses on clk; comparator output
  is asynchronous; vector_ack pulses when the cpu takes the vector.
*/
// How it works
// RULE_01 - writing one to bit 7 powers the comparator down
// RULE_02 - software clears interrupt enable before changing the disable bit
// RULE_03 - bit 6 set selects bandgap reference, clear selects positive pin
// RULE_04 - comparator output is synchronised into bit 5, one to two cycles late
// RULE_05 - flag bit 4 sets on output event matching selected mode
// RULE_06 - flag clears when the cpu takes the comparator vector
// RULE_07 - writing one to the flag clears it, zero leaves it
// RULE_08 - interrupt requested only with flag, enable bit 3 and global enable
// RULE_09 - bit 2 set routes comparator output to timer capture front end
// RULE_10 - bit 2 clear leaves no path to timer capture at all
// RULE_11 - software must also enable the timer capture interrupt
// RULE_12 - register answers at data offset 0x50 and i/o offset 0x30
// RULE_13 - mode 00 toggle, 10 falling, 11 rising, 01 reserved
`timescale 1ns/100ps
module acc_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // cpu access
  input wire acc_pkg::acc_cpu_req_t cpu_req,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  // cpu interrupt interface
  input wire logic global_int_enable,
  input wire logic vector_ack,
  output logic irq_req_q,
  // analog comparator core
  input wire logic comparator_raw,
  output acc_pkg::acc_analog_ctl_t analog_ctl_q,
  // timer input capture front end
  output logic capture_src_q
);
  import acc_pkg::*;

  logic disable_q;
  logic disable_d;
  logic bandgap_q;
  logic bandgap_d;
  logic flag_q;
  logic flag_d;
  logic ie_q;
  logic ie_d;
  logic route_q;
  logic route_d;
  acc_mode_t mode_q;
  acc_mode_t mode_d;
  logic prev_q;

  // address decode for both spaces
  wire ds_hit = (cpu_req.ds_addr == ACC_DS_OFFSET); // RULE_12
  wire io_hit = (cpu_req.io_addr == ACC_IO_OFFSET); // RULE_12
  wire reg_wr = (cpu_req.ds_we && ds_hit) || (cpu_req.io_we && io_hit);
  wire reg_rd = (cpu_req.ds_re && ds_hit) || (cpu_req.io_re && io_hit);
  wire [7:0] wd = cpu_req.wdata;

  // synchronised comparator output
  logic [0:0] out_sync_v;
  acc_sync #(
    .WIDTH(1),
    .STAGES(ACC_SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(comparator_raw),
    .sync_out(out_sync_v)
  );
  wire out_sync = out_sync_v[0]; // RULE_04

  // edge detection on the synchronised level only
  wire ev_rise = out_sync && !prev_q;
  wire ev_fall = !out_sync && prev_q;
  wire ev_toggle = ev_rise || ev_fall;
  // reserved mode never fires, so a stray code cannot flood the cpu
  wire ev_match = (mode_q == ACC_MODE_TOGGLE && ev_toggle)
    || (mode_q == ACC_MODE_FALL && ev_fall)
    || (mode_q == ACC_MODE_RISE && ev_rise); // RULE_13

  // read view of the register
  wire [7:0] reg_view = {disable_q, bandgap_q, out_sync, flag_q, ie_q, route_q, mode_q};

  // next-state for software fields
  assign disable_d = reg_wr ? wd[ACC_BIT_DISABLE] : disable_q; // RULE_01
  assign bandgap_d = reg_wr ? wd[ACC_BIT_BANDGAP] : bandgap_q; // RULE_03
  assign ie_d = reg_wr ? wd[ACC_BIT_IE] : ie_q; // RULE_08
  assign route_d = reg_wr ? wd[ACC_BIT_ROUTE] : route_q; // RULE_09
  assign mode_d = reg_wr ? acc_mode_t'({wd[ACC_BIT_MODE_HI], wd[ACC_BIT_MODE_LO]}) : mode_q;

  // flag: a new event wins over either kind of clear
  wire flag_wclr = reg_wr && wd[ACC_BIT_FLAG]; // RULE_07
  wire flag_hclr = vector_ack; // RULE_06
  assign flag_d = ev_match ? 1'h1 : ((flag_wclr || flag_hclr) ? 1'h0 : flag_q); // RULE_05

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      disable_q <= ACC_RESET[ACC_BIT_DISABLE];
      bandgap_q <= ACC_RESET[ACC_BIT_BANDGAP];
      flag_q <= ACC_RESET[ACC_BIT_FLAG];
      ie_q <= ACC_RESET[ACC_BIT_IE];
      route_q <= ACC_RESET[ACC_BIT_ROUTE];
      mode_q <= acc_mode_t'(ACC_RESET[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO]);
      prev_q <= 1'h0;
    end
    else
    begin
      disable_q <= disable_d;
      bandgap_q <= bandgap_d;
      flag_q <= flag_d;
      ie_q <= ie_d;
      route_q <= route_d;
      mode_q <= mode_d;
      prev_q <= out_sync;
    end
  end

  // outputs, all registered
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'h0;
      irq_req_q <= 1'h0;
      analog_ctl_q <= '0;
      capture_src_q <= 1'h0;
    end
    else
    begin
      rdata_q <= reg_rd ? reg_view : rdata_q; // RULE_12
      rvalid_q <= reg_rd;
      // enable is not qualified by disable: the cpu must drop ie first
      irq_req_q <= flag_d && ie_d && global_int_enable; // RULE_08 RULE_02
      analog_ctl_q.power_down <= disable_d; // RULE_01
      analog_ctl_q.bandgap_sel <= bandgap_d; // RULE_03
      // gated to zero so a cleared route leaves no path at all
      capture_src_q <= route_d && out_sync; // RULE_09 RULE_10
    end
  end

  // checks

  property p_power_down;
    @(posedge clk) disable iff (rst)
    reg_wr |=> (analog_ctl_q.power_down == $past(wd[ACC_BIT_DISABLE]));
  endproperty
  a_power_down: assert property (p_power_down) // RULE_01
    else $error("power down does not follow written disable bit");

  property p_bandgap_sel;
    @(posedge clk) disable iff (rst)
    reg_wr |=> (analog_ctl_q.bandgap_sel == $past(wd[ACC_BIT_BANDGAP]))
      && (bandgap_q == analog_ctl_q.bandgap_sel);
  endproperty
  a_bandgap_sel: assert property (p_bandgap_sel) // RULE_03
    else $error("positive input select disagrees with bandgap bit");

  property p_sync_delay;
    @(posedge clk) disable iff (rst)
    (comparator_raw ##1 comparator_raw ##1 comparator_raw) |-> out_sync;
  endproperty
  a_sync_delay: assert property (p_sync_delay) // RULE_04
    else $error("synchronised output late by more than two cycles");

  property p_sync_low;
    @(posedge clk) disable iff (rst)
    (!comparator_raw)[*3] |-> !out_sync;
  endproperty
  a_sync_low: assert property (p_sync_low) // RULE_04
    else $error("synchronised output stuck high");

  property p_flag_set;
    @(posedge clk) disable iff (rst)
    ev_match |=> flag_q;
  endproperty
  a_flag_set: assert property (p_flag_set) // RULE_05
    else $error("matching event did not set flag");

  property p_flag_vector_clr;
    @(posedge clk) disable iff (rst)
    (vector_ack && !ev_match) |=> !flag_q;
  endproperty
  a_flag_vector_clr: assert property (p_flag_vector_clr) // RULE_06
    else $error("vector acknowledge did not clear flag");

  property p_flag_write;
    @(posedge clk) disable iff (rst)
    (reg_wr && !vector_ack && !ev_match) |=> (flag_q == ($past(flag_q) && !$past(wd[ACC_BIT_FLAG])));
  endproperty
  a_flag_write: assert property (p_flag_write) // RULE_07
    else $error("flag write-one-to-clear misbehaved");

  property p_irq;
    @(posedge clk) disable iff (rst)
    irq_req_q == (flag_q && ie_q && $past(global_int_enable));
  endproperty
  a_irq: assert property (p_irq) // RULE_08
    else $error("interrupt request not gated by flag and enables");

  property p_irq_needs_flag;
    @(posedge clk) disable iff (rst)
    irq_req_q |-> (flag_q && ie_q);
  endproperty
  a_irq_needs_flag: assert property (p_irq_needs_flag) // RULE_08
    else $error("interrupt request without flag and enable");

  property p_route_on;
    @(posedge clk) disable iff (rst)
    (route_q && !reg_wr) |=> (capture_src_q == $past(out_sync));
  endproperty
  a_route_on: assert property (p_route_on) // RULE_09
    else $error("capture source does not follow comparator");

  property p_route_off;
    @(posedge clk) disable iff (rst)
    (!route_d) |=> !capture_src_q;
  endproperty
  a_route_off: assert property (p_route_off) // RULE_10
    else $error("capture source active with routing off");

  property p_read_back;
    @(posedge clk) disable iff (rst)
    reg_rd |=> (rvalid_q && rdata_q == $past(reg_view));
  endproperty
  a_read_back: assert property (p_read_back) // RULE_12
    else $error("read at register offset returned wrong data");

  property p_reserved_mode;
    @(posedge clk) disable iff (rst)
    (mode_q == ACC_MODE_RSVD && !flag_q) |=> !flag_q;
  endproperty
  a_reserved_mode: assert property (p_reserved_mode) // RULE_13
    else $error("reserved mode raised the flag");

  property p_rvalid_idle;
    @(posedge clk) disable iff (rst)
    !reg_rd |=> !rvalid_q;
  endproperty
  a_rvalid_idle: assert property (p_rvalid_idle) // RULE_12
    else $error("read valid without a read hit");

  property p_rdata_hold;
    @(posedge clk) disable iff (rst)
    !reg_rd |=> $stable(rdata_q);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) // RULE_12
    else $error("read data changed without a read hit");

  property p_ie_write;
    @(posedge clk) disable iff (rst)
    reg_wr |=> (ie_q == $past(wd[ACC_BIT_IE]));
  endproperty
  a_ie_write: assert property (p_ie_write) // RULE_08
    else $error("interrupt enable does not follow written bit");

  property p_route_write;
    @(posedge clk) disable iff (rst)
    reg_wr |=> (route_q == $past(wd[ACC_BIT_ROUTE]));
  endproperty
  a_route_write: assert property (p_route_write) // RULE_09
    else $error("capture routing does not follow written bit");

  property p_mode_write;
    @(posedge clk) disable iff (rst)
    reg_wr |=> (mode_q == $past(wd[ACC_BIT_MODE_HI:ACC_BIT_MODE_LO]));
  endproperty
  a_mode_write: assert property (p_mode_write) // RULE_13
    else $error("trigger mode does not follow written bits");

  property p_fields_hold;
    @(posedge clk) disable iff (rst)
    !reg_wr |=> $stable({disable_q, bandgap_q, ie_q, route_q, mode_q});
  endproperty
  a_fields_hold: assert property (p_fields_hold) // RULE_12
    else $error("control field changed without a register write");

  property p_flag_rise;
    @(posedge clk) disable iff (rst)
    ($rose(out_sync) && mode_q == ACC_MODE_RISE) |=> flag_q;
  endproperty
  a_flag_rise: assert property (p_flag_rise) // RULE_13 RULE_05
    else $error("rising output in rise mode did not set flag");

  property p_flag_fall;
    @(posedge clk) disable iff (rst)
    ($fell(out_sync) && mode_q == ACC_MODE_FALL) |=> flag_q;
  endproperty
  a_flag_fall: assert property (p_flag_fall) // RULE_13 RULE_05
    else $error("falling output in fall mode did not set flag");

  property p_flag_toggle;
    @(posedge clk) disable iff (rst)
    ($changed(out_sync) && mode_q == ACC_MODE_TOGGLE) |=> flag_q;
  endproperty
  a_flag_toggle: assert property (p_flag_toggle) // RULE_13 RULE_05
    else $error("output toggle in toggle mode did not set flag");

  property p_flag_quiet;
    @(posedge clk) disable iff (rst)
    (!$changed(out_sync) && !reg_wr && !vector_ack) |=> $stable(flag_q);
  endproperty
  a_flag_quiet: assert property (p_flag_quiet) // RULE_05
    else $error("flag changed with no event and no clear");

endmodule : acc_ctrl

//--- rtl/acc_pkg.sv
/*
  acc_pkg: constants and carrier types for the analog comparator control
  and status register.
  assumes: an 8-bit cpu with separate data-space and i/o-space strobes.
*/
package acc_pkg;

  // register placement
  localparam logic [15:0] ACC_DS_OFFSET = 16'h0050;
  localparam logic [15:0] ACC_IO_SHIFT = 16'h0020;
  localparam logic [15:0] ACC_IO_OFFSET_W = ACC_DS_OFFSET - ACC_IO_SHIFT;
  localparam logic [5:0] ACC_IO_OFFSET = ACC_IO_OFFSET_W[5:0];

  // field positions
  localparam int ACC_BIT_DISABLE = 7;
  localparam int ACC_BIT_BANDGAP = 6;
  localparam int ACC_BIT_OUT_SYNC = 5;
  localparam int ACC_BIT_FLAG = 4;
  localparam int ACC_BIT_IE = 3;
  localparam int ACC_BIT_ROUTE = 2;
  localparam int ACC_BIT_MODE_HI = 1;
  localparam int ACC_BIT_MODE_LO = 0;

  // reset value of every field
  localparam logic [7:0] ACC_RESET = 8'h00;

  // synchroniser depth
  localparam int ACC_SYNC_STAGES = 2;

  // interrupt trigger selection
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'h0,
    ACC_MODE_RSVD = 2'h1,
    ACC_MODE_FALL = 2'h2,
    ACC_MODE_RISE = 2'h3
  } acc_mode_t;

  // cpu access to the register, both address spaces
  typedef struct packed {
    logic [15:0] ds_addr;
    logic ds_we;
    logic ds_re;
    logic [5:0] io_addr;
    logic io_we;
    logic io_re;
    logic [7:0] wdata;
  } acc_cpu_req_t;

  // control levels towards the analog core
  typedef struct packed {
    logic power_down;
    logic bandgap_sel;
  } acc_analog_ctl_t;

endpackage : acc_pkg

//--- rtl/acc_sync.sv
/*
  acc_sync: multi-stage flip-flop synchroniser, one chain per bit.
  assumes: inputs are asynchronous to clk; only the last stage is read.
*/
`timescale 1ns/100ps
module acc_sync #(
  parameter int WIDTH = 1,
  parameter int STAGES = 2
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // async in, synchronised out
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // a single stage would hand a metastable level to the logic
  generate
    if (STAGES < 2)
    begin : g_bad_stages
      $error("acc_sync needs at least two stages");
    end
  endgenerate

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++)
    begin : g_bit
      logic [STAGES-1:0] chain_q;
      always_ff @(posedge clk or posedge rst)
      begin
        if (rst)
        begin
          chain_q <= '0;
        end
        else
        begin
          chain_q <= {chain_q[STAGES-2:0], async_in[gi]};
        end
      end
      assign sync_out[gi] = chain_q[STAGES-1];
    end
  endgenerate

endmodule : acc_sync

//--- bench/acc_comp_model.sv
/* acc_comp_model: comparator core, positive input select, timer capture request.
   assumes: bench drives both analog levels; no settling delay. */
`timescale 1ns/100ps
module acc_comp_model (
  // control from the register
  input wire acc_pkg::acc_analog_ctl_t analog_ctl,
  // analog levels
  input wire logic pin_above,
  input wire logic bandgap_above,
  // timer capture side
  input wire logic capture_src,
  input wire logic timer_capture_interrupt_enable,
  // result
  output logic comparator_raw,
  output logic capture_request
);
  import acc_pkg::*;
  // unpowered core held low, a real core may float
  assign comparator_raw = analog_ctl.power_down ? 1'h0 :
    (analog_ctl.bandgap_sel ? bandgap_above : pin_above);
  // timer raises a capture request only with its own enable set
  assign capture_request = capture_src && timer_capture_interrupt_enable;
endmodule : acc_comp_model

//--- bench/tb_analog_comparator_control.sv
/* tb_analog_comparator_control: self-checking bench for acc_ctrl.
   assumes: one clock, strobes driven at falling edges. */
`timescale 1ns/100ps
module tb_analog_comparator_control;
  import acc_pkg::*;
  logic clk = 1'h0;
  logic rst = 1'h1;
  acc_cpu_req_t req = '0;
  logic gie = 1'h0;
  logic vack = 1'h0;
  logic pin = 1'h0;
  logic bg = 1'h1;
  logic tcie = 1'h1;
  logic capreq;
  logic raw;
  logic [7:0] rdata;
  logic rvalid;
  logic irq;
  logic cap;
  acc_analog_ctl_t actl;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  acc_ctrl i_dut (.clk(clk), .rst(rst), .cpu_req(req), .rdata_q(rdata), .rvalid_q(rvalid),
    .global_int_enable(gie), .vector_ack(vack), .irq_req_q(irq), .comparator_raw(raw),
    .analog_ctl_q(actl), .capture_src_q(cap));
  acc_comp_model i_model (.analog_ctl(actl), .pin_above(pin), .bandgap_above(bg),
    .capture_src(cap), .timer_capture_interrupt_enable(tcie), .comparator_raw(raw),
    .capture_request(capreq));
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic acc_wr(input logic io, input logic [7:0] d);
    @(negedge clk);
    req.ds_addr = ACC_DS_OFFSET;
    req.io_addr = ACC_IO_OFFSET;
    req.ds_we = !io;
    req.io_we = io;
    req.wdata = d;
    @(negedge clk);
    req = '0;
  endtask : acc_wr
  task automatic acc_rd(input logic io, input logic [15:0] a, output logic [7:0] d,
    output logic v);
    @(negedge clk);
    req.ds_addr = a;
    req.io_addr = a[5:0];
    req.ds_re = !io;
    req.io_re = io;
    @(negedge clk);
    req = '0;
    d = rdata;
    v = rvalid;
  endtask : acc_rd
  task automatic rd_chk(input logic io, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    acc_rd(io, io ? ACC_IO_OFFSET_W : ACC_DS_OFFSET, d, v);
    chk("rvalid", 8'h01, {7'h0, v});
    chk("register", exp, d);
  endtask : rd_chk
  task automatic t_map();
    logic [7:0] d;
    logic v;
    rd_chk(1'h0, ACC_RESET);
    rd_chk(1'h1, ACC_RESET);
    acc_rd(1'h0, 16'h0051, d, v);
    chk("rvalid unmapped", 8'h00, {7'h0, v});
    acc_rd(1'h1, 16'h0031, d, v);
    chk("rvalid unmapped io", 8'h00, {7'h0, v});
  endtask : t_map
  task automatic t_ctl();
    acc_wr(1'h1, 8'hc0);
    cyc(1);
    chk("power_down", 8'h01, {7'h0, actl.power_down});
    chk("bandgap_sel", 8'h01, {7'h0, actl.bandgap_sel});
    rd_chk(1'h0, 8'hc0);
    acc_wr(1'h0, 8'h40);
    cyc(4);
    rd_chk(1'h0, 8'h70);
    bg = 1'h0;
    acc_wr(1'h0, 8'h10);
    cyc(4);
    chk("bandgap_sel off", 8'h00, {7'h0, actl.bandgap_sel});
  endtask : t_ctl
  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      acc_wr(1'h0, {6'h04, m[1:0]});
      pin = 1'h1;
      cyc(4);
      rd_chk(1'h0, {3'h1, m == 0 || m == 3, 2'h0, m[1:0]});
      acc_wr(1'h1, {6'h04, m[1:0]});
      pin = 1'h0;
      cyc(4);
      rd_chk(1'h1, {3'h0, m == 0 || m == 2, 2'h0, m[1:0]});
    end
  endtask : t_modes
  task automatic t_irq();
    acc_wr(1'h0, 8'h1b);
    pin = 1'h1;
    cyc(4);
    chk("irq masked", 8'h00, {7'h0, irq});
    gie = 1'h1;
    cyc(2);
    chk("irq", 8'h01, {7'h0, irq});
    acc_wr(1'h0, 8'h0b);
    cyc(1);
    chk("irq after zero write", 8'h01, {7'h0, irq});
    vack = 1'h1;
    cyc(1);
    vack = 1'h0;
    cyc(2);
    chk("irq after vector", 8'h00, {7'h0, irq});
    rd_chk(1'h0, 8'h2b);
    gie = 1'h0;
  endtask : t_irq
  task automatic t_route();
    acc_wr(1'h0, 8'h04);
    cyc(4);
    chk("capture routed", 8'h01, {7'h0, cap});
    chk("capture request", 8'h01, {7'h0, capreq});
    pin = 1'h0;
    cyc(4);
    chk("capture follows", 8'h00, {7'h0, cap});
    acc_wr(1'h0, 8'h00);
    pin = 1'h1;
    cyc(4);
    chk("capture cut", 8'h00, {7'h0, cap});
    chk("capture request cut", 8'h00, {7'h0, capreq});
  endtask : t_route
  task automatic finish_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  initial
  begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    t_map();
    t_ctl();
    t_modes();
    t_irq();
    t_route();
    finish_test();
  end
  // scenarios need under 150 cycles; the ceiling leaves a wide margin
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      n_mismatch++;
      finish_test();
    end
  end
endmodule : tb_analog_comparator_control
